/* src/qdc_cfg.svh */
// Purpose: Constants for the quadrature index and position tracker
// Assumes: Included by bare name; definitions only
// Notes: Widths here are defaults for module parameters
`ifndef QDC_CFG_SVH
`define QDC_CFG_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define QDC_POS_W 32
`define QDC_REV_W 16
`define QDC_PER_W 16
`define QDC_SYNC_STAGES 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define QDC_POS_RST 32'h0000_0000
`define QDC_REV_RST 16'h0000
`define QDC_PER_RST 16'h0000

// ----------------------------------------
// Quadrature bit positions in the sampled pair {phaseA, phaseB}
// ----------------------------------------
`define QDC_BIT_A 1
`define QDC_BIT_B 0

`endif

/* src/qdc_pkg.sv */
// Purpose: Types shared by the tracker files
// Assumes: Nothing beyond the cfg header
// Notes: Types only; numbers live in the cfg header
package qdc_pkg;

    // ----------------------------------------
    // Decoded step of one clock
    // ----------------------------------------
    typedef enum logic [2:0] {
        STEP_NONE = 3'b001,
        STEP_UP = 3'b010,
        STEP_DOWN = 3'b100
    } step_t;

    // ----------------------------------------
    // Revolution counter source
    // ----------------------------------------
    typedef enum logic {
        REV_FROM_INDEX = 1'b0,
        REV_FROM_MODULO = 1'b1
    } rev_source_t;

endpackage

/* src/input_sync.sv */
// Purpose: Two-flop synchroniser, one chain per bit
// Assumes: Single clock clk, synchronous active-high rst
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`include "qdc_cfg.svh"

module input_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk, // 200 MHz clock
    input wire logic rst, // Sync reset, high
    input wire logic [WIDTH-1:0] async, // Pin inputs
    output logic [WIDTH-1:0] synced // Synchronised copy
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta;
            logic stable;
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta <= 1'b0;
                    stable <= 1'b0;
                end else begin
                    meta <= async[i];
                    stable <= meta;
                end
            end
            assign synced[i] = stable;
        end
    endgenerate

endmodule

/* src/quadrature_index_position_tracker.sv */
// Purpose: Position and revolution counting from an encoder with index
// Assumes: Encoder pins are asynchronous; config ports are static or on clk
// Notes: Difference and period are captured from one cycle's state
//
// What this block does
// R1: Index-reset on, index revolution source, modulo off: index resets position.
// R2: Same configuration: each index event steps revolution count by direction.
// R3: Index-driven position reset and revolution step occur on index rising edge.
// R4: Modulo on, index-reset off: position wraps between initial and modulus values.
// R5: Modulo revolution source: revolution steps on position roll-over or under-flow.
// R6: Period measurement on: difference read captures difference and period holds.
// R7: Difference and period capture are atomic, even with a coincident edge.
// R8: Standard quadrature decode: forward counts up, reverse counts down.
`timescale 1ns/1ps
`include "qdc_cfg.svh"

module quadrature_index_position_tracker
    import qdc_pkg::*;
#(
    parameter int POS_W = `QDC_POS_W,
    parameter int REV_W = `QDC_REV_W,
    parameter int PER_W = `QDC_PER_W
) (
    input wire logic clk, // 200 MHz clock
    input wire logic rst, // Sync reset, high
    input wire logic phaseA, // Encoder phase A pin
    input wire logic phaseB, // Encoder phase B pin
    input wire logic indexPin, // Encoder index pin
    input wire logic index_resets_position, // Index resets position
    input wire logic revolution_source_select, // 0 index, 1 modulo events
    input wire logic modulo_count_enable, // Wrap between init and modulus
    input wire logic period_measure_enable, // Capture period with difference
    input wire logic [POS_W-1:0] initValue, // Initial / lower bound
    input wire logic [POS_W-1:0] modulusValue, // Modulus / upper bound
    input wire logic differenceRead, // Read strobe for difference
    output logic [POS_W-1:0] position, // Position counter
    output logic [REV_W-1:0] revolution, // Revolution counter
    output logic [POS_W-1:0] position_difference, // Steps since last read
    output logic [POS_W-1:0] position_difference_hold, // Captured difference
    output logic [PER_W-1:0] difference_period_hold, // Captured period
    output logic reverse, // Last step direction, 1 reverse
    output logic rollOver, // Modulo roll-over pulse
    output logic underFlow, // Modulo under-flow pulse
    output logic indexEvent // Index rising edge pulse
);

    // ----------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------
    logic [2:0] pinsSynced;
    logic [1:0] quadPrev;
    logic indexPrev;
    logic [1:0] quadNow;
    logic indexRise;
    step_t step;
    rev_source_t revSource;

    input_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async({indexPin, phaseA, phaseB}),
        .synced(pinsSynced)
    );

    assign quadNow[`QDC_BIT_A] = pinsSynced[1];
    assign quadNow[`QDC_BIT_B] = pinsSynced[0];
    assign revSource = rev_source_t'(revolution_source_select);

    always_ff @(posedge clk) begin
        if (rst) begin
            quadPrev <= 2'h0;
            indexPrev <= 1'b0;
        end else begin
            quadPrev <= quadNow;
            indexPrev <= pinsSynced[2];
        end
    end

    // Rising edge only, whichever way the shaft turns
    assign indexRise = pinsSynced[2] & ~indexPrev; // R3

    // Gray order forward: 00 -> 01 -> 11 -> 10 -> 00; double jumps ignored
    always_comb begin
        case ({quadPrev, quadNow}) // R8
            4'h1, 4'h7, 4'hE, 4'h8: step = STEP_UP;
            4'h2, 4'hB, 4'hD, 4'h4: step = STEP_DOWN;
            default: step = STEP_NONE;
        endcase
    end

    // ----------------------------------------
    // Mode decode and position counter
    // ----------------------------------------
    logic indexMode;
    logic wrapMode;
    logic atModulus;
    logic atInit;
    logic next_rollOver;
    logic next_underFlow;
    logic [POS_W-1:0] next_position;

    assign indexMode = index_resets_position & (revSource == REV_FROM_INDEX) & ~modulo_count_enable;
    assign wrapMode = modulo_count_enable & ~index_resets_position;
    assign atModulus = (position == modulusValue);
    assign atInit = (position == initValue);

    always_comb begin
        next_position = position;
        next_rollOver = 1'b0;
        next_underFlow = 1'b0;
        if (indexMode && indexRise) begin
            next_position = initValue; // R1
        end else if (step == STEP_UP) begin
            if (wrapMode && atModulus) begin
                next_position = initValue; // R4
                next_rollOver = 1'b1;
            end else begin
                next_position = position + 1'b1; // R8
            end
        end else if (step == STEP_DOWN) begin
            if (wrapMode && atInit) begin
                next_position = modulusValue; // R4
                next_underFlow = 1'b1;
            end else begin
                next_position = position - 1'b1; // R8
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            position <= `QDC_POS_RST;
            rollOver <= 1'b0;
            underFlow <= 1'b0;
        end else begin
            position <= next_position;
            rollOver <= next_rollOver;
            underFlow <= next_underFlow;
        end
    end

    // ----------------------------------------
    // Direction and revolution counter
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            reverse <= 1'b0;
        end else if (step == STEP_UP) begin
            reverse <= 1'b0;
        end else if (step == STEP_DOWN) begin
            reverse <= 1'b1;
        end
    end

    // Direction of the current step wins over the remembered one
    logic dirNow;
    assign dirNow = (step == STEP_NONE) ? reverse : (step == STEP_DOWN);

    always_ff @(posedge clk) begin
        if (rst) begin
            revolution <= `QDC_REV_RST;
            indexEvent <= 1'b0;
        end else begin
            indexEvent <= indexRise;
            if (revSource == REV_FROM_INDEX) begin
                if (indexMode && indexRise) begin
                    revolution <= dirNow ? revolution - 1'b1 : revolution + 1'b1; // R2 R3
                end
            end else if (next_rollOver) begin
                revolution <= revolution + 1'b1; // R5
            end else if (next_underFlow) begin
                revolution <= revolution - 1'b1; // R5
            end
        end
    end

    // ----------------------------------------
    // Difference and period capture
    // ----------------------------------------
    // A step landing in the read cycle is left for the next window, and the
    // period sample is taken from the same cycle, so the pair always matches.
    logic [POS_W-1:0] stepDelta;
    logic [PER_W-1:0] periodTimer;
    logic periodFull;

    always_comb begin
        case (step)
            STEP_UP: stepDelta = {{(POS_W-1){1'b0}}, 1'b1};
            STEP_DOWN: stepDelta = {POS_W{1'b1}};
            default: stepDelta = {POS_W{1'b0}};
        endcase
    end

    assign periodFull = &periodTimer;

    always_ff @(posedge clk) begin
        if (rst) begin
            position_difference <= `QDC_POS_RST;
            position_difference_hold <= `QDC_POS_RST;
        end else if (differenceRead) begin
            position_difference_hold <= position_difference; // R6 R7
            position_difference <= stepDelta; // R7
        end else begin
            position_difference <= position_difference + stepDelta;
        end
    end

    // Timer saturates rather than wraps, so a slow shaft reads as long
    always_ff @(posedge clk) begin
        if (rst) begin
            periodTimer <= `QDC_PER_RST;
            difference_period_hold <= `QDC_PER_RST;
        end else if (period_measure_enable && differenceRead) begin
            difference_period_hold <= periodTimer; // R6 R7
            periodTimer <= {{(PER_W-1){1'b0}}, 1'b1}; // R7
        end else if (period_measure_enable && !periodFull) begin
            periodTimer <= periodTimer + 1'b1;
        end else if (!period_measure_enable) begin
            periodTimer <= `QDC_PER_RST;
        end
    end

endmodule

/* verification/qdc_props.sv */
// Purpose: Port-level checks for the position tracker
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every tracker instance
`timescale 1ns/1ps
module qdc_checker #(
    parameter int POS_W = 32,
    parameter int REV_W = 16,
    parameter int PER_W = 16
) (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic index_resets_position, // Index mode
    input wire logic revolution_source_select, // Rev source
    input wire logic modulo_count_enable, // Modulo mode
    input wire logic period_measure_enable, // Period on
    input wire logic [POS_W-1:0] initValue, // Lower bound
    input wire logic [POS_W-1:0] modulusValue, // Upper bound
    input wire logic differenceRead, // Read strobe
    input wire logic [POS_W-1:0] position, // Position
    input wire logic [REV_W-1:0] revolution, // Revolutions
    input wire logic [POS_W-1:0] position_difference, // Difference
    input wire logic [POS_W-1:0] position_difference_hold, // Held difference
    input wire logic [PER_W-1:0] difference_period_hold, // Held period
    input wire logic reverse, // Direction
    input wire logic rollOver, // Wrap up
    input wire logic underFlow, // Wrap down
    input wire logic indexEvent // Index seen
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_ROLL_POS: assert property (rollOver |-> position == initValue)
        else $error("roll-over position wrong");
    AST_UNDER_POS: assert property (underFlow |-> position == modulusValue)
        else $error("under-flow position wrong");
    AST_ROLL_REV: assert property (rollOver && revolution_source_select |-> revolution == $past(revolution) + 1'b1)
        else $error("revolution not stepped up");
    AST_UNDER_REV: assert property (underFlow && revolution_source_select |-> revolution == $past(revolution) - 1'b1)
        else $error("revolution not stepped down");
    AST_IDX_RST: assert property (indexEvent && index_resets_position && !revolution_source_select
        && !modulo_count_enable |-> position == initValue)
        else $error("index did not reset position");
    AST_IDX_REV: assert property (indexEvent && index_resets_position && !revolution_source_select
        && !modulo_count_enable |-> revolution != $past(revolution))
        else $error("index did not step revolution");
    AST_IDX_PULSE: assert property (indexEvent |=> !indexEvent)
        else $error("index event longer than one cycle");
    AST_HOLD: assert property (differenceRead |=> position_difference_hold == $past(position_difference))
        else $error("difference not captured");
    AST_PER_OFF: assert property (!period_measure_enable && differenceRead |=> $stable(difference_period_hold))
        else $error("period captured while disabled");
    AST_STEP: assert property ($changed(position) && !rollOver && !underFlow && !indexEvent |->
        (position == $past(position) + 1'b1 && !reverse) || (position == $past(position) - 1'b1 && reverse))
        else $error("position step not one count");
    cover property (rollOver);
    cover property (underFlow);
    cover property (indexEvent && index_resets_position);
endmodule
bind quadrature_index_position_tracker qdc_checker #(.POS_W(POS_W), .REV_W(REV_W), .PER_W(PER_W)) u_chk (
    .clk(clk),
    .rst(rst),
    .index_resets_position(index_resets_position),
    .revolution_source_select(revolution_source_select),
    .modulo_count_enable(modulo_count_enable),
    .period_measure_enable(period_measure_enable),
    .initValue(initValue),
    .modulusValue(modulusValue),
    .differenceRead(differenceRead),
    .position(position),
    .revolution(revolution),
    .position_difference(position_difference),
    .position_difference_hold(position_difference_hold),
    .difference_period_hold(difference_period_hold),
    .reverse(reverse),
    .rollOver(rollOver),
    .underFlow(underFlow),
    .indexEvent(indexEvent)
);

/* verification/encoder_model.sv */
// Purpose: Behavioural rotary encoder with index output
// Assumes: Tasks are called from the bench
// Notes: Each level stands four clocks, above the two-clock minimum
`timescale 1ns/1ps
module encoder_model (
    input wire logic clk, // Sampling clock
    output logic phaseA, // Phase A
    output logic phaseB, // Phase B
    output logic indexPin // Index
);
    logic [1:0] st = 2'b00;
    initial {phaseA, phaseB, indexPin} = 3'h0;
    task automatic step(input logic fwd, input int n);
        for (int i = 0; i < n; i++) begin
            st = fwd ? {st[0], ~st[1]} : {~st[0], st[1]};
            @(posedge clk);
            #1 {phaseA, phaseB} = st;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic index();
        @(posedge clk);
        #1 indexPin = 1'b1;
        repeat (4) @(posedge clk);
        #1 indexPin = 1'b0;
    endtask
endmodule

/* verification/tb.sv */
// Purpose: Self-checking bench for the position tracker
// Assumes: Encoder model drives the pins
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic idxReset = 1'b0, sel = 1'b0, md = 1'b0, pme = 1'b0, dr = 1'b0;
    logic [31:0] initV = 32'h0, upperV = 32'h0, pos, pd, pdh;
    logic [15:0] rev, per;
    logic phA, phB, idx, rvs;
    int n_errors = 0, n_compared = 0, cyc = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    quadrature_index_position_tracker u_dut (.clk(clk), .rst(rst), .phaseA(phA), .phaseB(phB), .indexPin(idx),
        .index_resets_position(idxReset), .revolution_source_select(sel), .modulo_count_enable(md),
        .period_measure_enable(pme), .initValue(initV), .modulusValue(upperV), .differenceRead(dr),
        .position(pos), .revolution(rev), .position_difference(pd), .position_difference_hold(pdh),
        .difference_period_hold(per), .reverse(rvs), .rollOver(), .underFlow(), .indexEvent());
    encoder_model u_enc (.clk(clk), .phaseA(phA), .phaseB(phB), .indexPin(idx));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic mv(input logic fwd, input int n);
        u_enc.step(fwd, n);
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic pulse();
        u_enc.index();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Edge count taken before this edge's update lands
    task automatic rd(output int t);
        @(posedge clk);
        #1 dr = 1'b1;
        @(posedge clk);
        t = cyc;
        #1 dr = 1'b0;
    endtask
    task automatic t_count();
        mv(1'b1, 5);
        check(pos, 32'h5);
        check({31'h0, rvs}, 32'h0);
        mv(1'b0, 2);
        check(pos, 32'h3);
        check({31'h0, rvs}, 32'h1);
    endtask
    task automatic t_index();
        initV = 32'h10;
        idxReset = 1'b1;
        pulse();
        check(pos, 32'h10);
        check({16'h0, rev}, 32'hFFFF);
        mv(1'b1, 2);
        pulse();
        check(pos, 32'h10);
        check({16'h0, rev}, 32'h0);
        mv(1'b1, 1);
        idxReset = 1'b0;
        pulse();
        check(pos, 32'h11);
    endtask
    task automatic t_modulo();
        logic [15:0] r0;
        r0 = rev;
        upperV = 32'h12;
        md = 1'b1;
        sel = 1'b1;
        mv(1'b1, 2);
        check(pos, 32'h10);
        check({16'h0, rev}, {16'h0, r0 + 16'h1});
        mv(1'b0, 1);
        check(pos, 32'h12);
        check({16'h0, rev}, {16'h0, r0});
    endtask
    task automatic t_period();
        int t0, t1;
        logic [31:0] h;
        pme = 1'b1;
        rd(t0);
        mv(1'b1, 3);
        check(pd, 32'h3);
        rd(t1);
        check(pdh, 32'h3);
        check({16'h0, per}, t1 - t0);
        // Read lands on the edge that takes the decoded step
        fork
            u_enc.step(1'b0, 1);
            begin
                repeat (2) @(posedge clk);
                rd(t0);
            end
        join
        h = pdh;
        repeat (3) @(posedge clk);
        rd(t1);
        check(h, 32'h0);
        check(pdh, 32'hFFFFFFFF);
        check(h + pdh, 32'hFFFFFFFF);
        check({16'h0, per}, t1 - t0);
        h = {16'h0, per};
        pme = 1'b0;
        rd(t0);
        check({16'h0, per}, h);
    endtask
    task automatic results();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        t_count();
        t_index();
        t_modulo();
        t_period();
        results();
    end
    // Run needs well under a thousand cycles
    initial begin
        #20000;
        n_errors++;
        results();
    end
endmodule
